// [src/spcs_map.svh]
// Register indices, field positions, reset values and timing counts of the
// serial port control block. Assumes inclusion by bare name.
`ifndef SPCS_MAP_SVH
`define SPCS_MAP_SVH

// ==========================================
// Register indices (4-bit port address)
`define SPCS_REG_MODE 4'h0
`define SPCS_REG_BRR 4'h1
`define SPCS_REG_CTRL 4'h2
`define SPCS_REG_TXD 4'h3
`define SPCS_REG_STATUS 4'h4
`define SPCS_REG_RXD 4'h5
`define SPCS_REG_SMART_CARD_MODE_REG 4'h6
`define SPCS_REG_IRQ_ST 4'h7
`define SPCS_REG_IRQ_EN 4'h8
`define SPCS_REG_IRQ_CLR 4'h9

// ==========================================
// Control register fields
`define SPCS_TIE 7
`define SPCS_RIE 6
`define SPCS_TE 5
`define SPCS_RE 4
`define SPCS_CLOCK_SEL_HIGH 1
`define SPCS_CLOCK_SEL_LOW 0

// ==========================================
// Mode and smart card fields
`define SPCS_MODE_B7 7
`define SPCS_PAR_EN 5
`define SPCS_PAR_ODD 4
`define SPCS_SC_SEL 0

// ==========================================
// Status flags, stored as status bits 7..2
`define SPCS_TXE 5
`define SPCS_RXF 4
`define SPCS_OVERRUN_ERROR_FLAG 3
`define SPCS_FER 2
`define SPCS_PER 1
`define SPCS_TEND 0
`define SPCS_FLAG_LSB 2

// ==========================================
// Interrupt event bits
`define SPCS_EV_RXF 0
`define SPCS_EV_ERR 1
`define SPCS_EV_TXE 2
`define SPCS_EV_TEND 3

// ==========================================
// Reset values and timing counts
`define SPCS_RST_FLAGS 6'h21
`define SPCS_RST_BRR 8'hff
`define SPCS_TICK_LAST 4'hf
`define SPCS_TICK_MID 4'h7
`define SPCS_BIT_LAST 3'h7

`endif

// [src/spcs_pkg.sv]
// Types of the serial port control block: bus request, FSM states and the
// packed state records of both modules. Assumes spcs_map.svh alongside.
package spcs_pkg;

  // ==========================================
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spcs_bus_t;

  // ==========================================
  // Shifter states
  typedef enum logic [2:0] {
    tx_idle = 3'h0, tx_start = 3'h1, tx_data = 3'h2, tx_par = 3'h3, tx_stop = 3'h4
  } spcs_tx_t;

  typedef enum logic [2:0] {
    rx_idle = 3'h0, rx_start = 3'h1, rx_data = 3'h2, rx_par = 3'h3, rx_stop = 3'h4
  } spcs_rx_t;

  // ==========================================
  // Bit rate generator state
  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] div;
    logic tick;
  } spcs_baud_state_t;

  // ==========================================
  // Main block state
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] brr;
    logic [7:0] ctrl;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] smart_card_mode_reg;
    logic [5:0] flags;
    logic [5:0] seen;
    logic [3:0] irq_st;
    logic [3:0] irq_en;
    spcs_tx_t tx_st;
    spcs_rx_t rx_st;
    logic [3:0] tx_tc;
    logic [3:0] rx_tc;
    logic [2:0] tx_bc;
    logic [2:0] rx_bc;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic tx_par;
    logic rx_perr;
    logic [3:0] ck_tc;
    logic int_sck;
    logic [1:0] rxd_sy;
    logic [1:0] sck_sy;
    logic eff_prev;
    logic txd_o;
    logic sck_o;
    logic sck_oe;
    logic [7:0] rdata;
  } spcs_state_t;

endpackage : spcs_pkg

// [src/spcs_baud_gen.sv]
// Bit rate generator: 16x oversampling tick from core clock.
// Assumes prescale and divisor are static while enabled.
`timescale 1ns/100ps
`include "spcs_map.svh"

module spcs_baud_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Setting
  input wire logic en,
  input wire logic [1:0] presc,
  input wire logic [7:0] divisor,
  // Tick out
  output logic tick
);

  spcs_pkg::spcs_baud_state_t st, next_st;
  logic [5:0] pre_lim;

  // ==========================================
  // Prescaler of 1, 4, 16 or 64 cycles
  always_comb begin
    case (presc)
      2'h0: pre_lim = 6'h00;
      2'h1: pre_lim = 6'h03;
      2'h2: pre_lim = 6'h0f;
      default: pre_lim = 6'h3f;
    endcase
  end

  // Divide by divisor plus one, one-cycle tick
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!en) begin
      next_st.pre = 6'h00;
      next_st.div = 8'h00;
    end else if (st.pre == pre_lim) begin
      next_st.pre = 6'h00;
      if (st.div == divisor) begin
        next_st.div = 8'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.div = st.div + 8'h01;
      end
    end else begin
      next_st.pre = st.pre + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : spcs_baud_gen

// [src/spcs_top.sv]
// Serial port control unit with smart card clock control.
// Assumes a register master on core_clk; serial pins are asynchronous.
//
// Behaviour
// - receive interrupt enable gates full and error requests
// - request drops on flag clear or enable clear
// - transmitter disabled holds transmit empty flag high
// - transmit starts once empty flag cleared
// - receiver disable keeps receive status flags
// - receive starts on start bit or clock
// - smart card mode redefines clock bits and mode bit 7
// - clock bits pick source and pin output
// - smart card can hold clock pin level
// - hold off: port pin or clock out
// - hold on, both bits low: pin low
// - hold on: high bit alone holds high, low bit clocks
`timescale 1ns/100ps
`include "spcs_map.svh"

module spcs_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire spcs_pkg::spcs_bus_t bus,
  output logic [7:0] rdata,
  // Serial pins
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // Interrupts
  output logic receive_full_irq,
  output logic receive_error_irq,
  output logic irq
);

  spcs_pkg::spcs_state_t st, next_st;
  logic tick;
  logic sc, hold, sync, ext, sync_int;
  logic eff_sck, rise, fall, ck_run, tx_adv, rx_adv, rxd;

  // ==========================================
  // Bit rate generator
  spcs_baud_gen u_baud (
    .core_clk(core_clk),
    .rstn(rstn),
    .en(st.ctrl[`SPCS_TE] | st.ctrl[`SPCS_RE]),
    .presc(st.mode[1:0]),
    .divisor(st.brr),
    .tick(tick)
  );

  // ==========================================
  // Mode decode
  // Bit 7 of mode is clock hold in smart card mode, sync select otherwise
  assign sc = st.smart_card_mode_reg[`SPCS_SC_SEL];
  assign hold = sc & st.mode[`SPCS_MODE_B7];
  assign sync = ~sc & st.mode[`SPCS_MODE_B7];
  assign ext = sync & st.ctrl[`SPCS_CLOCK_SEL_HIGH];
  assign sync_int = sync & ~st.ctrl[`SPCS_CLOCK_SEL_HIGH];
  assign rxd = st.rxd_sy[1];

  // Serial clock edges, internal or from the pin
  assign eff_sck = ext ? st.sck_sy[1] : st.int_sck;
  assign rise = eff_sck & ~st.eff_prev;
  assign fall = ~eff_sck & st.eff_prev;
  // Internal sync clock only runs while there is work
  assign ck_run = (st.tx_st != spcs_pkg::tx_idle) | (st.ctrl[`SPCS_RE] & ~st.flags[`SPCS_RXF]);
  assign tx_adv = sync ? fall : (tick && st.tx_tc == `SPCS_TICK_LAST);
  assign rx_adv = sync ? rise : (tick && st.rx_tc == `SPCS_TICK_LAST);

  // ==========================================
  // Next state
  always_comb begin
    logic [7:0] rx_word;
    logic rx_done, rx_ferr, txe_set, tx_done;
    logic [3:0] ev;
    rx_word = st.rx_sh;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    txe_set = 1'b0;
    tx_done = 1'b0;
    ev = 4'h0;
    next_st = st;
    next_st.rdata = 8'h00;
    // Pin synchronisers
    next_st.rxd_sy = {st.rxd_sy[0], rxd_pin};
    next_st.sck_sy = {st.sck_sy[0], sck_i};
    next_st.eff_prev = eff_sck;

    // Internal clock: low half then high half of 16 ticks, idles high
    if (sync_int && !ck_run) begin
      next_st.ck_tc = 4'h0;
      next_st.int_sck = 1'b1;
    end else if (tick) begin
      next_st.ck_tc = st.ck_tc + 4'h1;
      next_st.int_sck = sync_int ? next_st.ck_tc[3] : 1'b1;
    end

    // Transmitter
    if (tick) begin
      next_st.tx_tc = st.tx_tc + 4'h1;
    end
    case (st.tx_st)
      spcs_pkg::tx_idle: begin
        if (st.ctrl[`SPCS_TE] && !st.flags[`SPCS_TXE]) begin
          next_st.tx_sh = st.txd;
          next_st.tx_par = (^st.txd) ^ st.mode[`SPCS_PAR_ODD];
          next_st.tx_tc = 4'h0;
          next_st.txd_o = sync; // Start bit in async mode
          next_st.tx_st = spcs_pkg::tx_start;
          txe_set = 1'b1;
        end
      end
      spcs_pkg::tx_start: begin
        if (tx_adv) begin
          next_st.txd_o = st.tx_sh[0];
          next_st.tx_bc = 3'h0;
          next_st.tx_st = spcs_pkg::tx_data;
        end
      end
      spcs_pkg::tx_data: begin
        if (tx_adv) begin
          if (st.tx_bc != `SPCS_BIT_LAST) begin
            next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
            next_st.txd_o = st.tx_sh[1];
            next_st.tx_bc = st.tx_bc + 3'h1;
          end else if (sync) begin
            next_st.txd_o = 1'b1;
            next_st.tx_st = spcs_pkg::tx_idle;
            tx_done = 1'b1;
          end else if (st.mode[`SPCS_PAR_EN]) begin
            next_st.txd_o = st.tx_par;
            next_st.tx_st = spcs_pkg::tx_par;
          end else begin
            next_st.txd_o = 1'b1;
            next_st.tx_st = spcs_pkg::tx_stop;
          end
        end
      end
      spcs_pkg::tx_par: begin
        if (tx_adv) begin
          next_st.txd_o = 1'b1;
          next_st.tx_st = spcs_pkg::tx_stop;
        end
      end
      spcs_pkg::tx_stop: begin
        if (tx_adv) begin
          next_st.tx_st = spcs_pkg::tx_idle;
          tx_done = 1'b1;
        end
      end
      default: begin
        next_st.tx_st = spcs_pkg::tx_idle;
      end
    endcase
    // Disabling aborts the frame and idles the line
    if (!st.ctrl[`SPCS_TE]) begin
      next_st.tx_st = spcs_pkg::tx_idle;
      next_st.txd_o = 1'b1;
    end

    // Receiver
    if (tick) begin
      next_st.rx_tc = st.rx_tc + 4'h1;
    end
    case (st.rx_st)
      spcs_pkg::rx_idle: begin
        if (st.ctrl[`SPCS_RE] && !sync && tick && !rxd) begin
          next_st.rx_tc = 4'h0;
          next_st.rx_st = spcs_pkg::rx_start;
        end else if (st.ctrl[`SPCS_RE] && sync && rise) begin
          next_st.rx_sh = {rxd, st.rx_sh[7:1]};
          next_st.rx_bc = 3'h1;
          next_st.rx_st = spcs_pkg::rx_data;
        end
      end
      spcs_pkg::rx_start: begin
        // Recheck mid start bit to reject glitches
        if (tick && st.rx_tc == `SPCS_TICK_MID) begin
          next_st.rx_tc = 4'h0;
          next_st.rx_bc = 3'h0;
          next_st.rx_perr = 1'b0;
          next_st.rx_st = rxd ? spcs_pkg::rx_idle : spcs_pkg::rx_data;
        end
      end
      spcs_pkg::rx_data: begin
        if (rx_adv) begin
          rx_word = {rxd, st.rx_sh[7:1]};
          next_st.rx_sh = rx_word;
          next_st.rx_bc = st.rx_bc + 3'h1;
          if (st.rx_bc == `SPCS_BIT_LAST) begin
            if (sync) begin
              rx_done = st.ctrl[`SPCS_RE];
              next_st.rx_st = spcs_pkg::rx_idle;
            end else begin
              next_st.rx_st = st.mode[`SPCS_PAR_EN] ? spcs_pkg::rx_par : spcs_pkg::rx_stop;
            end
          end
        end
      end
      spcs_pkg::rx_par: begin
        if (rx_adv) begin
          next_st.rx_perr = rxd ^ (^st.rx_sh) ^ st.mode[`SPCS_PAR_ODD];
          next_st.rx_st = spcs_pkg::rx_stop;
        end
      end
      spcs_pkg::rx_stop: begin
        if (rx_adv) begin
          rx_done = st.ctrl[`SPCS_RE];
          rx_ferr = ~rxd;
          next_st.rx_st = spcs_pkg::rx_idle;
        end
      end
      default: begin
        next_st.rx_st = spcs_pkg::rx_idle;
      end
    endcase
    // Disabling stops reception; status flags stay as they are
    if (!st.ctrl[`SPCS_RE]) begin
      next_st.rx_st = spcs_pkg::rx_idle;
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `SPCS_REG_MODE: next_st.mode = bus.wdata;
        `SPCS_REG_BRR: next_st.brr = bus.wdata;
        `SPCS_REG_CTRL: next_st.ctrl = bus.wdata;
        `SPCS_REG_TXD: next_st.txd = bus.wdata;
        `SPCS_REG_SMART_CARD_MODE_REG: next_st.smart_card_mode_reg = {7'h00, bus.wdata[`SPCS_SC_SEL]};
        `SPCS_REG_IRQ_EN: next_st.irq_en = bus.wdata[3:0];
        `SPCS_REG_IRQ_CLR: next_st.irq_st = st.irq_st & ~bus.wdata[3:0];
        `SPCS_REG_STATUS: begin
          // A flag clears only by writing 0 after reading it as 1
          for (int i = 0; i < 6; i++) begin
            if (!bus.wdata[i + `SPCS_FLAG_LSB] && st.seen[i]) begin
              next_st.flags[i] = 1'b0;
              next_st.seen[i] = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid in the following cycle only
    if (bus.rd) begin
      case (bus.addr)
        `SPCS_REG_MODE: next_st.rdata = st.mode;
        `SPCS_REG_BRR: next_st.rdata = st.brr;
        `SPCS_REG_CTRL: next_st.rdata = st.ctrl;
        `SPCS_REG_TXD: next_st.rdata = st.txd;
        `SPCS_REG_RXD: next_st.rdata = st.rxd;
        `SPCS_REG_SMART_CARD_MODE_REG: next_st.rdata = st.smart_card_mode_reg;
        `SPCS_REG_IRQ_ST: next_st.rdata = {4'h0, st.irq_st};
        `SPCS_REG_IRQ_EN: next_st.rdata = {4'h0, st.irq_en};
        `SPCS_REG_STATUS: begin
          next_st.rdata = {st.flags, 2'b00};
          next_st.seen = st.seen | st.flags;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Hardware events win over a same-cycle software clear
    if (txe_set) begin
      next_st.flags[`SPCS_TXE] = 1'b1;
      next_st.flags[`SPCS_TEND] = 1'b0;
      ev[`SPCS_EV_TXE] = 1'b1;
    end
    if (tx_done && st.flags[`SPCS_TXE]) begin
      next_st.flags[`SPCS_TEND] = 1'b1;
      ev[`SPCS_EV_TEND] = 1'b1;
    end
    if (rx_done) begin
      // An unread word blocks the new one and flags overrun
      if (st.flags[`SPCS_RXF]) begin
        next_st.flags[`SPCS_OVERRUN_ERROR_FLAG] = 1'b1;
        ev[`SPCS_EV_ERR] = 1'b1;
      end else begin
        next_st.rxd = rx_word;
        next_st.flags[`SPCS_RXF] = 1'b1;
        ev[`SPCS_EV_RXF] = 1'b1;
        if (rx_ferr || st.rx_perr) begin
          next_st.flags[`SPCS_FER] = st.flags[`SPCS_FER] | rx_ferr;
          next_st.flags[`SPCS_PER] = st.flags[`SPCS_PER] | st.rx_perr;
          ev[`SPCS_EV_ERR] = 1'b1;
        end
      end
    end
    next_st.irq_st = next_st.irq_st | ev;
    // Transmitter off pins the empty flag at one
    if (!st.ctrl[`SPCS_TE]) begin
      next_st.flags[`SPCS_TXE] = 1'b1;
    end

    // Clock pin function
    next_st.sck_oe = 1'b0;
    next_st.sck_o = 1'b1;
    if (sc) begin
      if (st.ctrl[`SPCS_CLOCK_SEL_LOW]) begin
        next_st.sck_oe = 1'b1;
        next_st.sck_o = st.ck_tc[3];
      end else if (hold) begin
        next_st.sck_oe = 1'b1;
        next_st.sck_o = st.ctrl[`SPCS_CLOCK_SEL_HIGH];
      end
    end else if (sync_int) begin
      next_st.sck_oe = 1'b1;
      next_st.sck_o = st.int_sck;
    end else if (!sync && !st.ctrl[`SPCS_CLOCK_SEL_HIGH] && st.ctrl[`SPCS_CLOCK_SEL_LOW]) begin
      next_st.sck_oe = 1'b1;
      next_st.sck_o = st.ck_tc[3];
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.brr <= `SPCS_RST_BRR;
      st.flags <= `SPCS_RST_FLAGS;
      st.int_sck <= 1'b1;
      st.eff_prev <= 1'b1;
      st.rxd_sy <= 2'h3;
      st.txd_o <= 1'b1;
      st.sck_o <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign rdata = st.rdata;
  assign txd_pin = st.txd_o;
  assign sck_o = st.sck_o;
  assign sck_oe = st.sck_oe;
  // Requests fall as soon as the flag or the enable goes
  assign receive_full_irq = st.ctrl[`SPCS_RIE] & st.flags[`SPCS_RXF];
  assign receive_error_irq = st.ctrl[`SPCS_RIE]
    & (st.flags[`SPCS_OVERRUN_ERROR_FLAG] | st.flags[`SPCS_FER] | st.flags[`SPCS_PER]);
  assign irq = |(st.irq_st & st.irq_en);

  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_tx_empty_held: assert property (!st.ctrl[`SPCS_TE] |=> st.flags[`SPCS_TXE])
    else $error("empty flag not held with transmitter off");
  a_rx_irq_gate: assert property (!st.ctrl[`SPCS_RIE] |-> !receive_full_irq && !receive_error_irq)
    else $error("receive request without enable");
  a_rx_irq_drop: assert property ($fell(st.flags[`SPCS_RXF]) |-> !receive_full_irq && $past(st.seen[`SPCS_RXF]))
    else $error("receive request stays after flag clear");
  a_tx_start: assert property (st.tx_st == spcs_pkg::tx_idle && st.ctrl[`SPCS_TE] && !st.flags[`SPCS_TXE]
    && !(bus.wr && bus.addr == `SPCS_REG_CTRL) |=> st.tx_st == spcs_pkg::tx_start && st.flags[`SPCS_TXE])
    else $error("transmit did not start");
  a_rx_flags_kept: assert property (!st.ctrl[`SPCS_RE] && !(bus.wr && bus.addr == `SPCS_REG_STATUS)
    |=> $stable(st.flags[`SPCS_RXF:`SPCS_PER]))
    else $error("receive flags changed with receiver off");
  a_rx_start_bit: assert property (st.ctrl[`SPCS_RE] && !sync && st.rx_st == spcs_pkg::rx_idle && tick && !rxd
    |=> st.rx_st == spcs_pkg::rx_start || !st.ctrl[`SPCS_RE])
    else $error("start bit missed");
  a_sc_port_pin: assert property (sc && !hold && !st.ctrl[`SPCS_CLOCK_SEL_LOW] |=> !sck_oe)
    else $error("clock pin driven as port");
  a_sc_hold_low: assert property (sc && hold && st.ctrl[1:0] == 2'h0 |=> sck_oe && !sck_o)
    else $error("clock pin not held low");
  a_sc_hold_high: assert property (sc && hold && st.ctrl[1:0] == 2'h2 |=> sck_oe && sck_o)
    else $error("clock pin not held high");
  a_ext_clk_in: assert property (ext ##1 ext |-> !sck_oe)
    else $error("clock pin driven with external clock");

  c_async_frame: cover property (st.rx_st == spcs_pkg::rx_stop ##1 st.flags[`SPCS_RXF]);
  c_overrun: cover property ($rose(st.flags[`SPCS_OVERRUN_ERROR_FLAG]));
  c_sync_tx_end: cover property (sync && $rose(st.flags[`SPCS_TEND]));
  c_sc_clock_out: cover property (sc && hold && sck_oe && $changed(sck_o));

endmodule : spcs_top

// [verif/spcs_serial_peer.sv]
// Remote serial device: sends async and clocked frames, receives async frames.
// Assumes 8 data bits, no parity, one stop bit, bit time set by bit_ns.
`timescale 1ns/100ps

module spcs_serial_peer #(
  parameter int bit_ns = 800,
  parameter int link_ns = 400
) (
  // Line from the block
  input wire logic txd_pin,
  // Lines towards the block
  output logic rxd_pin,
  output logic sck_i
);
  // Idle line high; link clock stands high between frames
  initial begin
    rxd_pin = 1'b1;
    sck_i = 1'b1;
  end

  // ==========================================
  // Async frame: start, LSB first, stop
  task automatic send_async(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_pin = f[i];
      #(bit_ns);
    end
  endtask : send_async

  // ==========================================
  // Clocked frame: data set on falling edge
  task automatic send_sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      sck_i = 1'b0;
      rxd_pin = d[i];
      #(link_ns / 2);
      sck_i = 1'b1;
      #(link_ns / 2);
    end
    // Released line must not look like the last bit
    rxd_pin = ~d[7];
  endtask : send_sync

  // ==========================================
  // Async receive, sampled mid-bit, bounded wait for start
  task automatic recv_async(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (txd_pin !== 1'b0 && n < 20000) begin
      #10;
      n++;
    end
    if (txd_pin === 1'b0) begin
      #(bit_ns / 2);
      for (int i = 0; i < 8; i++) begin
        #(bit_ns);
        d[i] = txd_pin;
      end
      #(bit_ns);
      ok = (txd_pin === 1'b1);
    end
  endtask : recv_async
endmodule : spcs_serial_peer

// [verif/spcs_top_tb_top.sv]
// Self-checking bench of the serial port control block.
// Assumes spcs_pkg, the design and the serial peer model compiled first.
`timescale 1ns/100ps
`include "spcs_map.svh"

module spcs_top_tb_top;
  logic core_clk;
  logic rstn;
  spcs_pkg::spcs_bus_t bus;
  logic [7:0] rdata;
  logic rxd_pin;
  logic txd_pin;
  logic sck_i;
  logic sck_o;
  logic sck_oe;
  logic receive_full_irq;
  logic receive_error_irq;
  logic irq;
  int err_total;
  int checks;
  int seed;
  logic [7:0] d;
  logic [7:0] got;
  logic ok;
  logic [1:0] e;

  // ==========================================
  // Clock of 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  spcs_top i_spcs_top (.core_clk(core_clk), .rstn(rstn), .bus(bus), .rdata(rdata), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .receive_full_irq(receive_full_irq),
    .receive_error_irq(receive_error_irq), .irq(irq));

  spcs_serial_peer i_spcs_serial_peer (.txd_pin(txd_pin), .rxd_pin(rxd_pin), .sck_i(sck_i));

  // ==========================================
  // Register port cycles and checks
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask : rd

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    chk(what, exp, v & m);
  endtask : chk_reg

  // Bounded poll of status flags
  task automatic poll(input logic [7:0] m);
    logic [7:0] v;
    v = 8'h00;
    for (int n = 0; n < 60 && (v & m) == 8'h00; n++) rd(`SPCS_REG_STATUS, v);
  endtask : poll

  // Pin outputs lag register writes
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask : settle

  // Clock pin {enable, held level} from selects and hold bit
  function automatic logic [1:0] pin_exp(input logic sc, input logic hold, input logic [1:0] cke);
    if (sc) return {cke[0] | hold, cke[1]};
    return {hold ? ~cke[1] : (~cke[1] & cke[0]), 1'b1};
  endfunction : pin_exp

  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Watchdog: all frames together take well under 1 ms
  initial begin
    #(2_000_000);
    err_total++;
    conclude();
  end

  // ==========================================
  // Main sequence
  initial begin
    seed = 3;
    err_total = 0;
    checks = 0;
    rstn = 1'b0;
    bus = '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    chk_reg(`SPCS_REG_MODE, 8'hff, 8'h00, "mode");
    chk_reg(`SPCS_REG_BRR, 8'hff, `SPCS_RST_BRR, "brr");
    chk_reg(`SPCS_REG_CTRL, 8'hff, 8'h00, "ctrl");
    chk_reg(4'hf, 8'hff, 8'h00, "unmapped");
    d = 8'($random(seed)) & 8'hcc;
    wr(`SPCS_REG_CTRL, d);
    chk_reg(`SPCS_REG_CTRL, 8'hff, d, "ctrl_rw");
    wr(`SPCS_REG_CTRL, 8'h00);
    // Empty flag cannot be cleared with the transmitter off
    chk_reg(`SPCS_REG_STATUS, 8'hff, 8'h84, "status");
    wr(`SPCS_REG_STATUS, 8'h00);
    chk_reg(`SPCS_REG_STATUS, 8'h80, 8'h80, "txe_held");
    // Format first, then one random word out
    wr(`SPCS_REG_BRR, 8'h00);
    wr(`SPCS_REG_MODE, 8'h00);
    wr(`SPCS_REG_CTRL, 8'h20);
    d = 8'($random(seed));
    fork
      i_spcs_serial_peer.recv_async(got, ok);
      begin
        wr(`SPCS_REG_TXD, d);
        chk_reg(`SPCS_REG_STATUS, 8'h80, 8'h80, "txe_before");
        chk("txd_idle", 8'h01, {7'h00, txd_pin});
        wr(`SPCS_REG_STATUS, 8'h7f);
      end
    join
    chk("tx_word", d, got);
    chk("tx_stop", 8'h01, {7'h00, ok});
    // Receive, then mask, unmask and clear the interrupt
    wr(`SPCS_REG_CTRL, 8'h50);
    wr(`SPCS_REG_IRQ_EN, 8'h01);
    d = 8'($random(seed));
    i_spcs_serial_peer.send_async(d);
    poll(8'h40);
    chk("rxf_irq", 8'h01, {7'h00, receive_full_irq});
    chk("irq", 8'h01, {7'h00, irq});
    chk_reg(`SPCS_REG_RXD, 8'hff, d, "rx_word");
    wr(`SPCS_REG_IRQ_EN, 8'h00);
    settle();
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(`SPCS_REG_IRQ_EN, 8'h01);
    wr(`SPCS_REG_IRQ_CLR, 8'h01);
    settle();
    chk("irq_cleared", 8'h00, {7'h00, irq});
    chk_reg(`SPCS_REG_IRQ_ST, 8'h01, 8'h00, "irq_st");
    wr(`SPCS_REG_STATUS, 8'hbf);
    settle();
    chk("rxf_irq_drop", 8'h00, {7'h00, receive_full_irq});
    // Second word kept, third lost to overrun
    d = 8'($random(seed));
    i_spcs_serial_peer.send_async(d);
    poll(8'h40);
    i_spcs_serial_peer.send_async(~d);
    poll(8'h20);
    chk("err_irq", 8'h01, {7'h00, receive_error_irq});
    wr(`SPCS_REG_CTRL, 8'h10);
    settle();
    chk("err_irq_drop", 8'h00, {7'h00, receive_error_irq});
    chk("rxf_irq_off", 8'h00, {7'h00, receive_full_irq});
    wr(`SPCS_REG_CTRL, 8'h00);
    chk_reg(`SPCS_REG_STATUS, 8'h60, 8'h60, "flags_kept");
    chk_reg(`SPCS_REG_RXD, 8'hff, d, "rx_kept");
    // Odd parity on: the peer's stop bit is taken as parity, wrong when the data has odd weight
    wr(`SPCS_REG_STATUS, 8'h00);
    wr(`SPCS_REG_MODE, 8'h30);
    wr(`SPCS_REG_CTRL, 8'h10);
    d = 8'($random(seed));
    i_spcs_serial_peer.send_async(d);
    poll(8'h40);
    chk_reg(`SPCS_REG_STATUS, 8'h18, {4'h0, ^d, 3'h0}, "parity_err");
    chk_reg(`SPCS_REG_RXD, 8'hff, d, "parity_word");
    wr(`SPCS_REG_CTRL, 8'h00);
    // Clocked receive on the external link clock
    wr(`SPCS_REG_STATUS, 8'h00);
    wr(`SPCS_REG_MODE, 8'h80);
    wr(`SPCS_REG_CTRL, 8'h12);
    settle();
    chk("ext_sck_oe", 8'h00, {7'h00, sck_oe});
    d = 8'($random(seed));
    i_spcs_serial_peer.send_sync(d);
    poll(8'h40);
    chk_reg(`SPCS_REG_RXD, 8'hff, d, "sync_word");
    // Clock pin in every select, hold and card combination
    for (int i = 0; i < 16; i++) begin
      wr(`SPCS_REG_CTRL, 8'h00);
      wr(`SPCS_REG_SMART_CARD_MODE_REG, {7'h00, i[3]});
      wr(`SPCS_REG_MODE, {i[2], 7'h00});
      wr(`SPCS_REG_CTRL, {6'h00, i[1:0]});
      settle();
      e = pin_exp(i[3], i[2], i[1:0]);
      chk("sck_oe", {7'h00, e[1]}, {7'h00, sck_oe});
      if (i[3] && i[2] && !i[0]) chk("sck_level", {7'h00, e[0]}, {7'h00, sck_o});
    end
    // Card clock out toggles every 8 ticks once the rate generator runs
    wr(`SPCS_REG_CTRL, 8'h21);
    settle();
    settle();
    ok = sck_o;
    repeat (8) @(negedge core_clk);
    chk("sck_toggle", {7'h00, ~ok}, {7'h00, sck_o});
    // Reset in mid-run returns flags and pins to idle
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    chk_reg(`SPCS_REG_STATUS, 8'hff, 8'h84, "status_rst");
    chk_reg(`SPCS_REG_CTRL, 8'hff, 8'h00, "ctrl_rst");
    chk("sck_oe_rst", 8'h00, {7'h00, sck_oe});
    conclude();
  end
endmodule : spcs_top_tb_top
